//--- hw/comm_wdog_defs.svh
// Constants for the output communication watchdog pair.
// Assumes inclusion by its bare name from the design files.
`ifndef COMM_WDOG_DEFS_SVH
`define COMM_WDOG_DEFS_SVH
`define ADDR_CTRL 4'h0
`define ADDR_MULT 4'h1
`define ADDR_SM_CNT 4'h2
`define ADDR_PD_CNT 4'h3
`define ADDR_STATUS 4'h4
`define CTRL_SM_EN 0
`define CTRL_PD_EN 1
`define CTRL_RST 16'h0003
`define MULT_RST 16'h09c2
`define SM_CNT_RST 16'h03e8
`define PD_CNT_RST 16'h03e8
`define MULT_MIN 16'h0001
`define LOCAL_CLK_NS 40
`define TICK_EXTRA 2
`define DEFAULT_TIMEOUT_MS 100
`endif

//--- hw/comm_wdog_pkg.sv
// Types shared by the output communication watchdog pair.
// Assumes the constants header sits in the include path.
package comm_wdog_pkg;
   typedef enum logic [1:0] {
      WD_OFF = 2'b00,
      WD_RUN = 2'b01,
      WD_TRIP = 2'b11
   } wd_state_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
endpackage

//--- hw/wdog_timer.sv
// One watchdog counter clocked by the shared tick.
// Assumes tick, kick and settings come from the local clock domain.
`timescale 1ns/100ps
module wdog_timer
   import comm_wdog_pkg::*;
#(
   parameter int CW = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic [CW-1:0] limit,
   input wire logic tick,
   input wire logic kick,
   output logic expired
);
   wd_state_t state_ff;
   logic [CW-1:0] cnt_ff;
   // A zero limit switches the watchdog off entirely.
   wire active = enable && (limit != '0);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_ff <= WD_OFF;
         cnt_ff <= '0;
      end else if (!active) begin
         state_ff <= WD_OFF;
         cnt_ff <= '0;
      end else begin
         case (state_ff)
            WD_OFF: begin
               state_ff <= WD_RUN;
               cnt_ff <= '0;
            end
            WD_RUN: begin
               if (kick) begin
                  cnt_ff <= '0;
               end else if (tick) begin
                  // Timeout is limit ticks of the shared tick, the first after a kick possibly partial.
                  if (cnt_ff + 1'b1 >= limit) begin
                     state_ff <= WD_TRIP;
                  end
                  cnt_ff <= cnt_ff + 1'b1;
               end
            end
            WD_TRIP: begin
               if (kick) begin
                  state_ff <= WD_RUN;
                  cnt_ff <= '0;
               end
            end
            default: begin
               state_ff <= WD_OFF;
            end
         endcase
      end
   end

   assign expired = (state_ff == WD_TRIP);
endmodule

//--- hw/output_comm_watchdog_pair.sv
// Operation
// - The fieldbus watchdog restarts on each good process data exchange and leaves expiry only on a later good access or when a register write switches it off.
// - An enabled fieldbus watchdog that sees no exchange for its time trips and forces all outputs low.
// - A trip leaves the operational state untouched while outputs are forced off.
// - An enabled application-side watchdog trips when no interface access arrives for its time.
// - One multiplier sets the tick of both watchdogs and each has its own count, timeout being count times tick.
// - A tick lasts multiplier plus two local clock periods of 40 ns, for multipliers up to 65534; at 65535 no tick comes.
// - Both watchdogs default to a 100 ms timeout.
// - The multiplier resets to 2498, giving a 100 us tick.
// - The fieldbus watchdog count resets to 1000 ticks.
// - Counts take 0 to 65535 and the multiplier 1 to 65535.
// - An enabled fieldbus watchdog with count zero is switched off and outputs hold.
// - Settings are written only by the configuring party at startup and otherwise keep their values.
// Watchdog pair guarding digital outputs behind a slave controller.
// Assumes CLK is the 25 MHz local clock domain; kicks are on that clock.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`include "comm_wdog_defs.svh"
module output_comm_watchdog_pair
   import comm_wdog_pkg::*;
#(
   parameter int NOUT = 8,
   parameter int CW = 16
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire comm_wdog_pkg::reg_req_t REQ,
   output logic [15:0] RDATA,
   input wire logic SM_EXCHANGE_OK,
   input wire logic PD_ACCESS,
   input wire logic OPERATIONAL_STATE_IN,
   input wire logic [NOUT-1:0] OUT_DATA,
   output logic [NOUT-1:0] OUT_PINS,
   output logic OPERATIONAL_STATE,
   output logic SM_EXPIRED,
   output logic PD_EXPIRED
);
   import comm_wdog_pkg::*;

   logic [15:0] ctrl_ff;
   logic [15:0] mult_ff;
   logic [CW-1:0] sm_cnt_ff;
   logic [CW-1:0] pd_cnt_ff;
   logic [15:0] pre_ff;
   logic tick_ff;
   logic [NOUT-1:0] out_ff;
   logic [15:0] rdata_ff;
   logic sm_exp;
   logic pd_exp;

   // Register writes; settings otherwise keep their values.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ctrl_ff <= `CTRL_RST;
         mult_ff <= `MULT_RST;
         sm_cnt_ff <= CW'(`SM_CNT_RST);
         pd_cnt_ff <= CW'(`PD_CNT_RST);
      end else if (REQ.wr) begin
         case (REQ.addr)
            `ADDR_CTRL: ctrl_ff <= REQ.wdata;
            `ADDR_MULT: begin
               // Zero is out of range, so it is held at the least value.
               mult_ff <= (REQ.wdata < `MULT_MIN) ? `MULT_MIN
                          : REQ.wdata;
            end
            `ADDR_SM_CNT: sm_cnt_ff <= CW'(REQ.wdata);
            `ADDR_PD_CNT: pd_cnt_ff <= CW'(REQ.wdata);
            default: begin
            end
         endcase
      end
   end

   // Shared prescaler: a tick every multiplier plus two clocks.
   // The compare is one bit wider, but at the largest multiplier the 16-bit pre_ff wraps and no tick ever comes.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         pre_ff <= '0;
         tick_ff <= 1'b0;
      end else if (17'(pre_ff) >= 17'(mult_ff) + 17'(`TICK_EXTRA - 1)) begin
         pre_ff <= '0;
         tick_ff <= 1'b1;
      end else begin
         pre_ff <= pre_ff + 16'h0001;
         tick_ff <= 1'b0;
      end
   end

   wdog_timer #(.CW(CW)) u_sm (
      .clk(CLK),
      .rst_n(RST_N),
      .enable(ctrl_ff[`CTRL_SM_EN]),
      .limit(sm_cnt_ff),
      .tick(tick_ff),
      .kick(SM_EXCHANGE_OK),
      .expired(sm_exp)
   );

   wdog_timer #(.CW(CW)) u_pd (
      .clk(CLK),
      .rst_n(RST_N),
      .enable(ctrl_ff[`CTRL_PD_EN]),
      .limit(pd_cnt_ff),
      .tick(tick_ff),
      .kick(PD_ACCESS),
      .expired(pd_exp)
   );

   // Outputs go low on a fieldbus trip only.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         out_ff <= '0;
      end else if (sm_exp) begin
         out_ff <= '0;
      end else begin
         out_ff <= OUT_DATA;
      end
   end

   // Read data one cycle after the strobe.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rdata_ff <= '0;
      end else if (REQ.rd) begin
         case (REQ.addr)
            `ADDR_CTRL: rdata_ff <= ctrl_ff;
            `ADDR_MULT: rdata_ff <= mult_ff;
            `ADDR_SM_CNT: rdata_ff <= 16'(sm_cnt_ff);
            `ADDR_PD_CNT: rdata_ff <= 16'(pd_cnt_ff);
            `ADDR_STATUS: rdata_ff <= {14'h0000, pd_exp, sm_exp};
            default: rdata_ff <= 16'h0000;
         endcase
      end else begin
         rdata_ff <= 16'h0000;
      end
   end

   assign RDATA = rdata_ff;
   assign OUT_PINS = out_ff;
   // The state machine passes through unchanged by any trip.
   assign OPERATIONAL_STATE = OPERATIONAL_STATE_IN;
   assign SM_EXPIRED = sm_exp;
   assign PD_EXPIRED = pd_exp;
endmodule

//--- dv/comm_far_side.sv
// Model of the fieldbus master and the application processor kicks.
// Assumes the bench switches each source on or off in step with clk.
`timescale 1ns/100ps
module comm_far_side (
   input wire logic clk,
   input wire logic sm_on,
   input wire logic pd_on,
   output logic sm_kick = 1'b0,
   output logic pd_kick = 1'b0
);
   logic [1:0] ph_ff = 2'h0;
   // Kicks come every fourth cycle, a slow but healthy peer.
   always_ff @(posedge clk) begin
      ph_ff <= ph_ff + 2'h1;
      sm_kick <= sm_on && ph_ff == 2'h0;
      pd_kick <= pd_on && ph_ff == 2'h2;
   end
endmodule

//--- dv/comm_wdog_sva.sv
// Checker on the ports of the watchdog pair.
// Assumes the bind below attaches it to every pair instance.
`timescale 1ns/100ps
module comm_wdog_sva
   import comm_wdog_pkg::*;
#(parameter int NOUT = 8) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire comm_wdog_pkg::reg_req_t REQ,
   input wire logic [15:0] RDATA,
   input wire logic SM_EXCHANGE_OK,
   input wire logic PD_ACCESS,
   input wire logic OPERATIONAL_STATE_IN,
   input wire logic [NOUT-1:0] OUT_DATA,
   input wire logic [NOUT-1:0] OUT_PINS,
   input wire logic OPERATIONAL_STATE,
   input wire logic SM_EXPIRED,
   input wire logic PD_EXPIRED
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   out_off_a: assert property (
      SM_EXPIRED && $past(SM_EXPIRED) |-> OUT_PINS == '0)
      else $error("outputs not off");
   op_keep_a: assert property (
      OPERATIONAL_STATE == OPERATIONAL_STATE_IN) else $error("state lost");
   sm_clear_a: assert property (
      SM_EXPIRED && SM_EXCHANGE_OK |=> !SM_EXPIRED) else $error("no clear");
   sm_hold_a: assert property (
      $fell(SM_EXPIRED) |-> $past(SM_EXCHANGE_OK) || $past(REQ.wr)
      || $past(REQ.wr, 2)) else $error("cleared without kick");
   sm_rise_a: assert property (
      $rose(SM_EXPIRED) |-> !$past(SM_EXCHANGE_OK)) else $error("sm trip");
   pd_rise_a: assert property (
      $rose(PD_EXPIRED) |-> !$past(PD_ACCESS)) else $error("pd trip");
   pd_clear_a: assert property (
      PD_EXPIRED && PD_ACCESS |=> !PD_EXPIRED) else $error("pd no clear");
   status_rd_a: assert property (
      $past(REQ.rd) && $past(REQ.addr) == 4'h4 |->
      RDATA == {14'h0, $past(PD_EXPIRED), $past(SM_EXPIRED)})
      else $error("status wrong");
endmodule
bind output_comm_watchdog_pair comm_wdog_sva #(.NOUT(NOUT)) i_sva (.*);

//--- dv/output_comm_watchdog_pair_tb_top.sv
// Register and timeout tests of the watchdog pair.
// Assumes a fast setting: multiplier 1, counts 3 and 5.
`timescale 1ns/100ps
`include "comm_wdog_defs.svh"
module output_comm_watchdog_pair_tb_top;
   import comm_wdog_pkg::*;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   reg_req_t req = '0;
   logic [15:0] rdata;
   logic sm_ok, pd_acc, sm_on = 1'b1, pd_on = 1'b1, op_in = 1'b1;
   logic [7:0] od = 8'ha5;
   logic [7:0] op_pins;
   logic op, sm_exp, pd_exp;
   logic [15:0] rv[6] = '{16'h3, 16'h9c2, 16'h3e8, 16'h3e8, 16'h0, 16'h0};
   int fails = 0;
   int cmp_count = 0;
   int n;
   always #5 CLK = ~CLK;
   comm_far_side i_far (.clk(CLK), .sm_on(sm_on), .pd_on(pd_on),
      .sm_kick(sm_ok), .pd_kick(pd_acc));
   output_comm_watchdog_pair #(.NOUT(8)) i_dut (.CLK(CLK), .RST_N(RST_N),
      .REQ(req), .RDATA(rdata), .SM_EXCHANGE_OK(sm_ok), .PD_ACCESS(pd_acc),
      .OPERATIONAL_STATE_IN(op_in), .OUT_DATA(od), .OUT_PINS(op_pins),
      .OPERATIONAL_STATE(op), .SM_EXPIRED(sm_exp), .PD_EXPIRED(pd_exp));
   task automatic chk(input logic [15:0] s, e, input string w);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", w, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge CLK);
      req <= '0;
      @(posedge CLK);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      req <= '{a, 16'h0, 1'b0, 1'b1};
      @(posedge CLK);
      req <= '0;
      #1 chk(rdata, e, "rdata");
      @(posedge CLK);
   endtask
   // The gap is counted from the last kick seen, so phase does not matter.
   task automatic wait_exp(input logic p, input int lo, hi);
      n = 0;
      while ((p ? pd_exp : sm_exp) !== 1'b1 && n < 40) begin
         @(posedge CLK);
         #1 n = (p ? pd_acc : sm_ok) ? 0 : n + 1;
      end
      chk({15'h0, n >= lo && n <= hi}, 16'h1, "expiry delay");
      @(posedge CLK);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge CLK);
      fails++;
      tally_and_finish();
   end
   initial begin
      repeat (4) @(posedge CLK);
      RST_N <= 1'b1;
      @(posedge CLK);
      foreach (rv[i]) rd(4'(i), rv[i]);
      wr(`ADDR_MULT, 16'h0);
      rd(`ADDR_MULT, `MULT_MIN);
      wr(`ADDR_SM_CNT, 16'h3);
      wr(`ADDR_PD_CNT, 16'h5);
      $display("test registers done");
      sm_on <= 1'b0;
      wait_exp(1'b0, 5, 11);
      #1 chk(16'(op_pins), 16'h0, "outputs");
      chk(16'(op), 16'h1, "op state");
      chk(16'(pd_exp), 16'h0, "pd flag");
      repeat (10) @(posedge CLK);
      #1 chk(16'(sm_exp), 16'h1, "sm flag held");
      @(posedge CLK);
      sm_on <= 1'b1;
      repeat (8) @(posedge CLK);
      #1 chk(16'(sm_exp), 16'h0, "sm flag");
      chk(16'(op_pins), 16'ha5, "outputs back");
      $display("test sm done");
      @(posedge CLK);
      pd_on <= 1'b0;
      wait_exp(1'b1, 11, 17);
      rd(`ADDR_STATUS, 16'h2);
      pd_on <= 1'b1;
      repeat (8) @(posedge CLK);
      #1 chk(16'(pd_exp), 16'h0, "pd flag");
      $display("test pd done");
      @(posedge CLK);
      wr(`ADDR_SM_CNT, 16'h0);
      sm_on <= 1'b0;
      od <= 8'h3c;
      op_in <= 1'b0;
      repeat (40) @(posedge CLK);
      #1 chk(16'(sm_exp), 16'h0, "zero count");
      chk(16'(op_pins), 16'h3c, "outputs held");
      chk(16'(op), 16'h0, "op follows");
      $display("test zero count done");
      @(posedge CLK);
      wr(`ADDR_CTRL, 16'h2);
      wr(`ADDR_SM_CNT, 16'h3);
      rd(`ADDR_CTRL, 16'h2);
      repeat (40) @(posedge CLK);
      #1 chk(16'(sm_exp), 16'h0, "sm disabled");
      chk(16'(op_pins), 16'h3c, "outputs on");
      $display("test disable done");
      tally_and_finish();
   end
endmodule
